// ### logic/adc_consts.svh
// Constants for the converter output and data-ready control block
`ifndef ADC_CONSTS_SVH
`define ADC_CONSTS_SVH

// Encoding clock periods from sampling edge to output word
`define ADC_PIPE_LATENCY 4
// Register stages between FIFO head and output word
`define ADC_PIPE_STAGES (`ADC_PIPE_LATENCY - 1)
// Raw conversion result width, covers codes 0 to 256
`define ADC_CODE_W 9
`define ADC_WORD_W 8
`define ADC_CODE_LOW 9'h000
`define ADC_CODE_HIGH 9'h100
`define ADC_WORD_MAX 8'hff
// Strobe rising edges after restart up to the first valid word
`define ADC_FIRST_RISE 2'h3
`define ADC_FIFO_DEPTH 32

`endif

// ### logic/adc_pkg.sv
// Types shared by the converter output control block
package adc_pkg;

  typedef enum logic {
    ADC_HELD,
    ADC_RUN
  } adc_mode_type;

  typedef struct packed {
    logic oor;
    logic [7:0] data;
  } adc_word_type;

endpackage

// ### logic/adc_fifo.sv
// Sample FIFO with registered read data and valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module adc_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wr;
    logic [PW-1:0] rd;
    logic [CW-1:0] cnt;
    logic ov;
    logic [WIDTH-1:0] od;
  } adc_fifo_state_type;

  adc_fifo_state_type state_reg;
  adc_fifo_state_type state_next;
  logic push;
  logic pop_mem;
  logic load;

  // Output register is one extra slot; depth must be a power of two
  assign in_ready = (state_reg.cnt < CW'(DEPTH));
  assign out_valid = state_reg.ov;
  assign out_data = state_reg.od;

  always_comb begin
    state_next = state_reg;
    push = in_valid && in_ready;
    load = !state_reg.ov || out_ready;
    pop_mem = load && (state_reg.cnt != '0);
    if (push) begin
      state_next.mem[state_reg.wr] = in_data;
      state_next.wr = state_reg.wr + PW'(1);
    end
    if (load) begin
      state_next.ov = pop_mem;
    end
    if (pop_mem) begin
      state_next.od = state_reg.mem[state_reg.rd];
      state_next.rd = state_reg.rd + PW'(1);
    end
    state_next.cnt = state_reg.cnt + CW'(push) - CW'(pop_mem);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

endmodule
`default_nettype wire

// ### logic/adc_out_ctrl.sv
// Converter output pipeline, word coding and data-ready strobe control
//
// What this block does
// - Sample on rise, output four periods later
// - Strobe toggles once per new word
// - Strobe launched on falling, data rising
// - Reset low forces strobe zero, holds
// - Strobe restarts after reset input rises
// - Clock low at release: next fall
// - Clock high at release: one period
// - Third strobe rise marks first word
// - Select high binary, low Gray
// - Out-of-range high for codes 0, 256
// - Eight-bit word, bit zero least significant
`timescale 1ns/1ps
`default_nettype none
`include "adc_consts.svh"
module adc_out_ctrl
  import adc_pkg::*;
#(
  parameter int FIFO_DEPTH = `ADC_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Pins from outside the clock domain
  input wire logic enc_clk,
  input wire logic strobe_reset_n,
  input wire logic gray_binary_select,
  input wire logic [`ADC_CODE_W-1:0] conv_code,
  // Output word
  output logic [`ADC_WORD_W-1:0] word_data,
  output logic out_of_range,
  // Data-ready strobe
  output logic word_strobe,
  output logic word_strobe_inv,
  // Status
  output logic first_word_mark,
  output logic sample_dropped
);

  // ***************************************************************
  // State
  // ***************************************************************
  typedef struct packed {
    logic enc_s1;
    logic enc_s2;
    logic enc_s3;
    logic rst_s1;
    logic rst_s2;
    logic sel_s1;
    logic sel_s2;
    logic [`ADC_CODE_W-1:0] code_s1;
    logic [`ADC_CODE_W-1:0] code_s2;
    adc_mode_type mode;
    logic skip;
    logic strobe;
    logic [1:0] rise_cnt;
    logic first;
    logic dropped;
    logic [`ADC_PIPE_STAGES-1:0][`ADC_CODE_W-1:0] pipe;
    adc_word_type word;
  } adc_state_type;

  adc_state_type state_reg;
  adc_state_type state_next;
  logic rise_evt;
  logic fall_evt;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [`ADC_CODE_W-1:0] fifo_out_data;
  logic [`ADC_CODE_W-1:0] last_code;

  assign rise_evt = state_reg.enc_s2 && !state_reg.enc_s3;
  assign fall_evt = !state_reg.enc_s2 && state_reg.enc_s3;
  assign last_code = state_reg.pipe[`ADC_PIPE_STAGES-1];

  // ***************************************************************
  // Word coding
  // ***************************************************************
  function automatic adc_word_type encode(
    input logic [`ADC_CODE_W-1:0] code,
    input logic binary_sel
  );
    adc_word_type w;
    logic [`ADC_WORD_W-1:0] bin;
    w.oor = (code == `ADC_CODE_LOW) || (code >= `ADC_CODE_HIGH);
    // Code 256 saturates to full scale rather than wrapping to zero
    bin = (code >= `ADC_CODE_HIGH) ? `ADC_WORD_MAX : code[7:0];
    if (binary_sel) begin
      w.data = bin;
    end else begin
      w.data = bin ^ (bin >> 1);
    end
    return w;
  endfunction

  // ***************************************************************
  // Sample buffer
  // ***************************************************************
  // Drained one word per encoding rise, so it holds the word in flight
  adc_fifo #(
    .WIDTH(`ADC_CODE_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(ref_clk),
    .reset(reset),
    .in_valid(rise_evt),
    .in_ready(fifo_in_ready),
    .in_data(state_reg.code_s2),
    .out_valid(fifo_out_valid),
    .out_ready(rise_evt),
    .out_data(fifo_out_data)
  );

  // ***************************************************************
  // Next state
  // ***************************************************************
  always_comb begin
    state_next = state_reg;
    state_next.enc_s1 = enc_clk;
    state_next.enc_s2 = state_reg.enc_s1;
    state_next.enc_s3 = state_reg.enc_s2;
    state_next.rst_s1 = strobe_reset_n;
    state_next.rst_s2 = state_reg.rst_s1;
    state_next.sel_s1 = gray_binary_select;
    state_next.sel_s2 = state_reg.sel_s1;
    state_next.code_s1 = conv_code;
    state_next.code_s2 = state_reg.code_s1;
    state_next.first = 1'b0;
    state_next.dropped = rise_evt && !fifo_in_ready;
    if (rise_evt) begin
      // One FIFO slot plus three stages make four periods
      state_next.pipe[0] = fifo_out_valid ? fifo_out_data : '0;
      for (int i = 1; i < `ADC_PIPE_STAGES; i++) begin
        state_next.pipe[i] = state_reg.pipe[i-1];
      end
      state_next.word = encode(last_code, state_reg.sel_s2);
    end
    if (!state_reg.rst_s2) begin
      state_next.mode = ADC_HELD;
      state_next.strobe = 1'b0;
      state_next.skip = 1'b0;
      state_next.rise_cnt = 2'h0;
    end else begin
      unique case (state_reg.mode)
        ADC_HELD: begin
          state_next.mode = ADC_RUN;
          // High clock at release skips the nearest fall
          state_next.skip = state_reg.enc_s2;
        end
        ADC_RUN: begin
          if (fall_evt) begin
            if (state_reg.skip) begin
              state_next.skip = 1'b0;
            end else begin
              state_next.strobe = !state_reg.strobe;
              if (!state_reg.strobe &&
                  state_reg.rise_cnt != `ADC_FIRST_RISE) begin
                state_next.rise_cnt = state_reg.rise_cnt + 2'h1;
                state_next.first =
                  (state_reg.rise_cnt == 2'h2);
              end
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ***************************************************************
  // Outputs
  // ***************************************************************
  // Gated by the synced level so assertion of the clear acts at once
  assign word_strobe = state_reg.strobe && state_reg.rst_s2;
  assign word_strobe_inv = !word_strobe;
  assign word_data = state_reg.word.data;
  assign out_of_range = state_reg.word.oor;
  assign first_word_mark = state_reg.first;
  assign sample_dropped = state_reg.dropped;

  // ***************************************************************
  // Assertions
  // ***************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  sequence s_release_low;
    state_reg.rst_s2 && state_reg.mode == ADC_HELD && !state_reg.enc_s2;
  endsequence

  sequence s_release_high;
    state_reg.rst_s2 && state_reg.mode == ADC_HELD && state_reg.enc_s2;
  endsequence

  sequence s_skip_armed;
    state_reg.mode == ADC_RUN && state_reg.skip;
  endsequence

  property p_word_on_rise;
    $changed(word_data) |-> $past(rise_evt);
  endproperty
  a_word_on_rise: assert property (p_word_on_rise)
    else $error("word changed without encoding rise");

  property p_strobe_on_fall;
    $changed(state_reg.strobe) && state_reg.rst_s2 &&
      $past(state_reg.rst_s2) |-> $past(fall_evt);
  endproperty
  a_strobe_on_fall: assert property (p_strobe_on_fall)
    else $error("strobe toggled without falling edge");

  property p_strobe_toggle;
    fall_evt && state_reg.mode == ADC_RUN && !state_reg.skip &&
      state_reg.rst_s2 |=> state_reg.strobe != $past(state_reg.strobe);
  endproperty
  a_strobe_toggle: assert property (p_strobe_toggle)
    else $error("strobe missed a toggle");

  property p_held_low;
    !state_reg.rst_s2 |-> !word_strobe ##1 !state_reg.strobe;
  endproperty
  a_held_low: assert property (p_held_low)
    else $error("strobe not zero under strobe reset");

  property p_restart_low;
    s_release_low |=> state_reg.mode == ADC_RUN && !state_reg.skip;
  endproperty
  a_restart_low: assert property (p_restart_low)
    else $error("low clock release did not arm next fall");

  property p_restart_high;
    s_release_high |=> s_skip_armed;
  endproperty
  a_restart_high: assert property (p_restart_high)
    else $error("high clock release did not arm a skip");

  // The skipped fall must leave the strobe low and disarm the skip
  property p_skip_fall;
    s_skip_armed ##0 (fall_evt && state_reg.rst_s2)
      |=> $stable(state_reg.strobe) && !state_reg.skip;
  endproperty
  a_skip_fall: assert property (p_skip_fall)
    else $error("skipped fall changed the strobe");

  // Restart count must start from zero after every clear
  property p_held_mode;
    !state_reg.rst_s2 |=> state_reg.mode == ADC_HELD &&
      state_reg.rise_cnt == 2'h0 && !state_reg.skip;
  endproperty
  a_held_mode: assert property (p_held_mode)
    else $error("strobe clear did not rearm the restart");

  property p_first_mark;
    first_word_mark |-> state_reg.strobe && $past(!state_reg.strobe) &&
      state_reg.rise_cnt == `ADC_FIRST_RISE;
  endproperty
  a_first_mark: assert property (p_first_mark)
    else $error("first word mark off the third strobe rise");

  property p_oor;
    rise_evt && (last_code == `ADC_CODE_LOW) |=> out_of_range;
  endproperty
  a_oor: assert property (p_oor)
    else $error("out of range missing for code zero");

  property p_binary;
    rise_evt && state_reg.sel_s2 && last_code < `ADC_CODE_HIGH
      |=> word_data == $past(last_code[7:0]) && !$past(last_code == 0)
        == !out_of_range;
  endproperty
  a_binary: assert property (p_binary)
    else $error("binary word does not match code");

  property p_gray;
    rise_evt && !state_reg.sel_s2 && last_code < `ADC_CODE_HIGH
      |=> word_data ==
        ($past(last_code[7:0]) ^ ($past(last_code[7:0]) >> 1));
  endproperty
  a_gray: assert property (p_gray)
    else $error("gray word does not match code");

  // Top code saturates to full scale in either coding
  property p_oor_high;
    rise_evt && last_code >= `ADC_CODE_HIGH |=> out_of_range &&
      word_data == ($past(state_reg.sel_s2) ? `ADC_WORD_MAX :
        (`ADC_WORD_MAX ^ (`ADC_WORD_MAX >> 1)));
  endproperty
  a_oor_high: assert property (p_oor_high)
    else $error("code 256 did not give full scale out of range");

  // A lost sample would shift every later word by one period
  property p_no_drop;
    !sample_dropped;
  endproperty
  a_no_drop: assert property (p_no_drop)
    else $error("sample lost in the buffer");

endmodule
`default_nettype wire

// ### testbench/adc_capture_model.sv
// Capture-side model that latches output words on both strobe edges
`timescale 1ns/1ps
`default_nettype none
module adc_capture_model
  import adc_pkg::*;
(
  // Clock
  input wire logic ref_clk,
  // From the converter
  input wire logic word_strobe,
  input wire logic [7:0] word_data,
  input wire logic out_of_range,
  input wire logic first_word_mark,
  // Captured word
  output var logic cap_valid,
  output var logic cap_first,
  output var adc_word_type cap_word
);
  logic strobe_prev;

  // Either strobe edge marks a fresh word, so both are latched
  always @(posedge ref_clk) begin
    cap_valid <= word_strobe !== strobe_prev;
    cap_first <= first_word_mark & word_strobe;
    cap_word <= '{oor: out_of_range, data: word_data};
    strobe_prev <= word_strobe;
  end
endmodule
`default_nettype wire

// ### testbench/adc_out_ctrl_tb_top.sv
// Self-checking bench for the converter output and strobe control
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin fail_count++; \
  $display("BAD t=%0t got %h exp %h", $time, a, b); end end
module adc_out_ctrl_tb_top
  import adc_pkg::*;
;
  logic ref_clk, reset, enc_clk, strobe_reset_n, gray_binary_select;
  logic [8:0] conv_code;
  logic [7:0] word_data, prev_word;
  logic out_of_range, word_strobe, word_strobe_inv, first_word_mark;
  logic sample_dropped, cap_valid, cap_first, prev_strobe, prev_enc;
  adc_word_type cap_word, exp_w;
  adc_word_type exp_q[$];
  bit live, push_on, started;
  int fail_count, checks_done, nf, rises, i, n, m, seed;

  adc_out_ctrl dut (.ref_clk(ref_clk), .reset(reset), .enc_clk(enc_clk),
    .strobe_reset_n(strobe_reset_n), .gray_binary_select(gray_binary_select),
    .conv_code(conv_code), .word_data(word_data),
    .out_of_range(out_of_range), .word_strobe(word_strobe),
    .word_strobe_inv(word_strobe_inv), .first_word_mark(first_word_mark),
    .sample_dropped(sample_dropped));
  adc_capture_model partner (.ref_clk(ref_clk), .word_strobe(word_strobe),
    .word_data(word_data), .out_of_range(out_of_range),
    .first_word_mark(first_word_mark), .cap_valid(cap_valid),
    .cap_first(cap_first), .cap_word(cap_word));

  function automatic adc_word_type exp_word(logic [8:0] c, logic bin);
    logic [7:0] d;
    d = c[8] ? 8'hff : c[7:0];
    if (!bin) d = d ^ (d >> 1);
    return '{oor: (c == 9'h000) || (c == 9'h100), data: d};
  endfunction

  task automatic finish_test;
    if (fail_count == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // ************************************************
  // Clocks; the encoding clock never stops
  // ************************************************
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    enc_clk = 1'b0;
    #3;
    forever #40 enc_clk = ~enc_clk;
  end

  // ************************************************
  // Sample codes, steady across each rising edge
  // ************************************************
  initial begin
    @(negedge enc_clk);
    forever begin
      @(posedge ref_clk);
      m++;
      conv_code <= (m % 8 == 0) ? 9'h000 : (m % 8 == 4) ? 9'h100 :
        9'($urandom % 257);
      @(negedge enc_clk);
    end
  end
  always @(posedge enc_clk) begin
    if (push_on) exp_q.push_back(exp_word(conv_code, gray_binary_select));
  end

  // ************************************************
  // Watcher
  // ************************************************
  always @(posedge ref_clk) begin
    if (live && word_strobe !== prev_strobe) begin
      `CHK(enc_clk, 1'b0)
      `CHK(word_strobe_inv, ~word_strobe)
      if (word_strobe === 1'b1) rises++;
    end
    if (live && word_data !== prev_word) `CHK(enc_clk, 1'b1)
    if (live) `CHK(sample_dropped, 1'b0)
    if (live && cap_first) begin
      started = 1;
      `CHK(rises, 3)
    end
    if (live && started && cap_valid) begin
      if (exp_q.size() == 0) exp_w = '1;
      else exp_w = exp_q.pop_front();
      `CHK(cap_word, exp_w)
    end
    prev_strobe = word_strobe;
    prev_word = word_data;
  end

  // ************************************************
  // Main sequence
  // ************************************************
  initial begin
    reset = 1'b1;
    strobe_reset_n = 1'b1;
    gray_binary_select = 1'b1;
    conv_code = 9'h000;
    seed = $urandom(32'hf246);
    repeat (8) @(posedge ref_clk);
    // Outputs still cleared while reset is held
    `CHK({word_data, out_of_range, word_strobe}, 10'h000)
    `CHK(word_strobe_inv, 1'b1)
    reset <= 1'b0;
    for (i = 0; i < 4; i++) begin
      live = 0;
      push_on = 0;
      started = 0;
      exp_q.delete();
      @(posedge ref_clk);
      strobe_reset_n <= 1'b0;
      gray_binary_select <= i[1];
      repeat (6) @(posedge ref_clk);
      repeat (24) begin
        @(posedge ref_clk);
        `CHK(word_strobe, 1'b0)
      end
      if (i[0]) @(posedge enc_clk);
      else @(negedge enc_clk);
      repeat (2) @(posedge ref_clk);
      strobe_reset_n <= 1'b1;
      live = 1;
      push_on = 1;
      rises = 0;
      nf = 0;
      n = 0;
      prev_enc = enc_clk;
      while (word_strobe !== 1'b1 && n < 40) begin
        @(posedge ref_clk);
        if (prev_enc && !enc_clk) nf++;
        prev_enc = enc_clk;
        n++;
      end
      if (n >= 40) begin
        fail_count++;
        break;
      end
      `CHK(nf, i[0] ? 2 : 1)
      repeat (14) @(posedge enc_clk);
      `CHK(started, 1'b1)
    end
    finish_test();
  end
endmodule
`default_nettype wire
